/* File: logic/pmcs_pkg.sv */
package pmcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h4c;
  localparam logic [7:0] IDX_STAT = 8'h4e;
  localparam logic [7:0] IDX_IDLO = 8'h50;
  localparam logic [7:0] IDX_IDHI = 8'h52;
  localparam logic [7:0] IDX_CMIR = 8'h60;
  localparam logic [7:0] IDX_SMIR = 8'h62;

  localparam int ADDR_W = 10;

  // Control word field positions
  localparam int C_LOOP   = 14;
  localparam int C_SPD    = 13;
  localparam int C_ANEN   = 12;
  localparam int C_PWDN   = 11;
  localparam int C_RST    = 9;
  localparam int C_DUP    = 8;
  localparam int C_XVAR   = 5;
  localparam int C_FMDIX  = 4;
  localparam int C_NOMDIX = 3;
  localparam int C_RSV2   = 2;
  localparam int C_TXDIS  = 1;

  // Control mirror positions
  localparam int M_LOOP   = 8;
  localparam int M_SPD    = 6;
  localparam int M_ANEN   = 7;
  localparam int M_PWDN   = 11;
  localparam int M_RST    = 13;
  localparam int M_DUP    = 5;
  localparam int M_FMDIX  = 9;
  localparam int M_NOMDIX = 10;
  localparam int M_RSV2   = 12;
  localparam int M_TXDIS  = 14;

  // Status word and status mirror positions
  localparam int S_ANC   = 5;
  localparam int S_ANCAP = 3;
  localparam int S_LINK  = 2;
  localparam int S_EXT   = 0;
  localparam int SM_XVAR = 15;
  localparam int SM_ANC  = 6;
  localparam int SM_LINK = 5;

  localparam logic [15:0] CTRL_RST = 16'h3120;
  localparam logic [4:0]  STAT_CAP = 5'h0f;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic full_duplex;
    logic an_enable;
    logic an_restart;
    logic power_down;
    logic crossover_variant_select;
    logic force_mdix;
    logic auto_mdix_off;
    logic tx_disable;
  } pmcs_ctrl_s;

  typedef struct packed {
    logic an_complete;
    logic an_failed;
    logic an_speed_100;
    logic an_full_duplex;
    logic link_up;
  } pmcs_stat_s;

endpackage

/* File: logic/pmcs_phy_regs.sv */
`timescale 1ns/10ps
module pmcs_phy_regs #(
  // Arbitrary neutral identifier values
  parameter logic [15:0] ID_LOW  = 16'h5a5a,
  parameter logic [15:0] ID_HIGH = 16'h00a5
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic [pmcs_pkg::ADDR_W-1:0] avm_address_i,
  input  wire logic                       avm_read_i,
  input  wire logic                       avm_write_i,
  input  wire logic [3:0]                 avm_byteenable_i,
  input  wire logic [31:0]                avm_writedata_i,
  output logic      [31:0]                avm_readdata_o,
  output logic                            avm_waitrequest_o,
  input  wire pmcs_pkg::pmcs_stat_s       phy_stat_i,
  output pmcs_pkg::pmcs_ctrl_s            phy_ctrl_o
);

  logic        ack;
  logic        wr_go;
  logic        hit_c;
  logic        hit_m;
  logic        hit_s;
  logic [7:0]  idx;
  logic [15:0] wd;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic [15:0] cmir_word;
  logic [15:0] smir_word;
  logic [15:0] rd_word;

  logic loopback;
  logic force_100;
  logic an_enable;
  logic power_down;
  logic restart;
  logic force_full;
  logic xover_var;
  logic force_mdix;
  logic mdix_off;
  logic rsv_bit2;
  logic tx_disable;

  assign idx   = avm_address_i[9:2];
  assign wd    = avm_writedata_i[15:0];
  assign wr_go = avm_write_i & ack;
  assign hit_c = wr_go && (idx == pmcs_pkg::IDX_CTRL);
  assign hit_m = wr_go && (idx == pmcs_pkg::IDX_CMIR);
  assign hit_s = wr_go && (idx == pmcs_pkg::IDX_SMIR);

  // One wait cycle, then the answer
  assign avm_waitrequest_o = (avm_read_i | avm_write_i) & ~ack;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avm_read_i | avm_write_i) & ~ack;
    end
  end

  // New value of a shared bit from either address
  function automatic logic upd(input logic old, input int cp,
                               input int mp);
    logic r;
    r = old;
    if (hit_c && avm_byteenable_i[cp/8]) begin
      r = wd[cp];
    end else if (hit_m && avm_byteenable_i[mp/8]) begin
      r = wd[mp];
    end
    return r;
  endfunction

  // Shared storage of control fields
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loopback   <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_LOOP];
      force_100  <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_SPD];
      an_enable  <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_ANEN];
      power_down <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_PWDN];
      force_full <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_DUP];
      force_mdix <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_FMDIX];
      mdix_off   <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_NOMDIX];
      rsv_bit2   <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_RSV2];
      tx_disable <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_TXDIS];
    end else begin
      loopback   <= upd(loopback, pmcs_pkg::C_LOOP,
                        pmcs_pkg::M_LOOP);
      force_100  <= upd(force_100, pmcs_pkg::C_SPD,
                        pmcs_pkg::M_SPD);
      an_enable  <= upd(an_enable, pmcs_pkg::C_ANEN,
                        pmcs_pkg::M_ANEN);
      power_down <= upd(power_down, pmcs_pkg::C_PWDN,
                        pmcs_pkg::M_PWDN);
      force_full <= upd(force_full, pmcs_pkg::C_DUP,
                        pmcs_pkg::M_DUP);
      force_mdix <= upd(force_mdix, pmcs_pkg::C_FMDIX,
                        pmcs_pkg::M_FMDIX);
      mdix_off   <= upd(mdix_off, pmcs_pkg::C_NOMDIX,
                        pmcs_pkg::M_NOMDIX);
      rsv_bit2   <= upd(rsv_bit2, pmcs_pkg::C_RSV2,
                        pmcs_pkg::M_RSV2);
      tx_disable <= upd(tx_disable, pmcs_pkg::C_TXDIS,
                        pmcs_pkg::M_TXDIS);
    end
  end

  // Crossover variant, shared with the status mirror
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xover_var <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_XVAR];
    end else if (hit_c && avm_byteenable_i[0]) begin
      xover_var <= wd[pmcs_pkg::C_XVAR];
    end else if (hit_s && avm_byteenable_i[1]) begin
      xover_var <= wd[pmcs_pkg::SM_XVAR];
    end
  end

  // Restart stands one cycle, then clears itself
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      restart <= pmcs_pkg::CTRL_RST[pmcs_pkg::C_RST];
    end else begin
      restart <= upd(1'b0, pmcs_pkg::C_RST, pmcs_pkg::M_RST);
    end
  end

  // Drive to the PHY
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_ctrl_o <= '0;
    end else begin
      phy_ctrl_o.loopback    <= loopback;
      phy_ctrl_o.speed_100   <= an_enable ? phy_stat_i.an_speed_100
                                          : force_100;
      phy_ctrl_o.full_duplex <= (an_enable && !phy_stat_i.an_failed)
                                ? phy_stat_i.an_full_duplex
                                : force_full;
      phy_ctrl_o.an_enable   <= an_enable;
      phy_ctrl_o.an_restart  <= restart;
      phy_ctrl_o.power_down  <= power_down;
      phy_ctrl_o.crossover_variant_select <= xover_var;
      phy_ctrl_o.force_mdix    <= force_mdix;
      phy_ctrl_o.auto_mdix_off <= mdix_off;
      phy_ctrl_o.tx_disable    <= tx_disable;
    end
  end

  // Read images
  always_comb begin
    ctrl_word = '0;
    ctrl_word[pmcs_pkg::C_LOOP]   = loopback;
    ctrl_word[pmcs_pkg::C_SPD]    = force_100;
    ctrl_word[pmcs_pkg::C_ANEN]   = an_enable;
    ctrl_word[pmcs_pkg::C_PWDN]   = power_down;
    ctrl_word[pmcs_pkg::C_RST]    = restart;
    ctrl_word[pmcs_pkg::C_DUP]    = force_full;
    ctrl_word[pmcs_pkg::C_XVAR]   = xover_var;
    ctrl_word[pmcs_pkg::C_FMDIX]  = force_mdix;
    ctrl_word[pmcs_pkg::C_NOMDIX] = mdix_off;
    ctrl_word[pmcs_pkg::C_RSV2]   = rsv_bit2;
    ctrl_word[pmcs_pkg::C_TXDIS]  = tx_disable;
  end

  always_comb begin
    cmir_word = '0;
    cmir_word[pmcs_pkg::M_LOOP]   = loopback;
    cmir_word[pmcs_pkg::M_SPD]    = force_100;
    cmir_word[pmcs_pkg::M_ANEN]   = an_enable;
    cmir_word[pmcs_pkg::M_PWDN]   = power_down;
    cmir_word[pmcs_pkg::M_RST]    = restart;
    cmir_word[pmcs_pkg::M_DUP]    = force_full;
    cmir_word[pmcs_pkg::M_FMDIX]  = force_mdix;
    cmir_word[pmcs_pkg::M_NOMDIX] = mdix_off;
    cmir_word[pmcs_pkg::M_RSV2]   = rsv_bit2;
    cmir_word[pmcs_pkg::M_TXDIS]  = tx_disable;
  end

  always_comb begin
    stat_word = '0;
    stat_word[15:11] = pmcs_pkg::STAT_CAP;
    stat_word[pmcs_pkg::S_ANC]   = phy_stat_i.an_complete;
    stat_word[pmcs_pkg::S_ANCAP] = 1'b1;
    stat_word[pmcs_pkg::S_LINK]  = phy_stat_i.link_up;
    stat_word[pmcs_pkg::S_EXT]   = 1'b0;
  end

  always_comb begin
    smir_word = '0;
    smir_word[pmcs_pkg::SM_XVAR] = xover_var;
    smir_word[pmcs_pkg::SM_ANC]  = phy_stat_i.an_complete;
    smir_word[pmcs_pkg::SM_LINK] = phy_stat_i.link_up;
  end

  always_comb begin
    case (idx)
      pmcs_pkg::IDX_CTRL: rd_word = ctrl_word;
      pmcs_pkg::IDX_STAT: rd_word = stat_word;
      pmcs_pkg::IDX_IDLO: rd_word = ID_LOW;
      pmcs_pkg::IDX_IDHI: rd_word = ID_HIGH;
      pmcs_pkg::IDX_CMIR: rd_word = cmir_word;
      pmcs_pkg::IDX_SMIR: rd_word = smir_word;
      default:            rd_word = 16'h0000;
    endcase
  end

  // Read data captured in the wait cycle, stands while acked
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avm_readdata_o <= 32'h0000_0000;
    end else if (avm_read_i && !ack) begin
      avm_readdata_o <= {16'h0000, rd_word};
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_wr_ctrl_hi;
    hit_c && avm_byteenable_i[1];
  endsequence

  sequence s_wr_ctrl_lo;
    hit_c && avm_byteenable_i[0];
  endsequence

  sequence s_rd_cap(logic [7:0] i);
    avm_read_i && !ack && (idx == i);
  endsequence

  AST_LOOPBACK: assert property (
    s_wr_ctrl_hi |-> ##2 phy_ctrl_o.loopback == $past(wd[14], 2))
    else $error("loopback does not follow control write");

  AST_SPEED_FORCE: assert property (
    !an_enable |=> phy_ctrl_o.speed_100 == $past(force_100))
    else $error("forced speed wrong with negotiation off");

  AST_AN_ENABLE: assert property (
    s_wr_ctrl_hi |=> an_enable == $past(wd[12])
    ##1 phy_ctrl_o.an_enable == $past(wd[12], 2))
    else $error("negotiation enable not taken");

  AST_RESTART_SC: assert property (
    s_wr_ctrl_hi ##0 wd[9] |=> restart ##1 !restart && phy_ctrl_o.an_restart
    ##1 !phy_ctrl_o.an_restart)
    else $error("restart does not clear itself");

  AST_DUPLEX_FALLBACK: assert property (
    (!an_enable || phy_stat_i.an_failed)
    |=> phy_ctrl_o.full_duplex == $past(force_full))
    else $error("duplex does not fall back to forced bit");

  AST_XOVER_MIRROR: assert property (
    hit_s && avm_byteenable_i[1] && !hit_c |=> xover_var == $past(wd[15]))
    else $error("crossover variant mirror write lost");

  AST_MDIX_OFF: assert property (
    s_wr_ctrl_lo |-> ##2 phy_ctrl_o.auto_mdix_off == $past(wd[3], 2))
    else $error("crossover detection bit not driven");

  AST_TX_DISABLE: assert property (
    hit_m && avm_byteenable_i[1] |-> ##2
    phy_ctrl_o.tx_disable == $past(wd[14], 2))
    else $error("transmit disable mirror write lost");

  AST_STAT_CONST: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT) |=> avm_readdata_o[15:11] == 5'h0f
    && avm_readdata_o[3] && !avm_readdata_o[0] && !avm_waitrequest_o)
    else $error("status capability bits wrong");

  AST_AN_DONE: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT)
    |=> avm_readdata_o[5] == $past(phy_stat_i.an_complete))
    else $error("negotiation complete bit wrong");

  AST_LINK: assert property (
    s_rd_cap(pmcs_pkg::IDX_SMIR)
    |=> avm_readdata_o[5] == $past(phy_stat_i.link_up))
    else $error("link bit wrong in status mirror");

  AST_ID_LOW: assert property (
    s_rd_cap(pmcs_pkg::IDX_IDLO) |=> avm_readdata_o == {16'h0000, ID_LOW})
    else $error("low identifier wrong");

  AST_ID_HIGH: assert property (
    s_rd_cap(pmcs_pkg::IDX_IDHI) |=> avm_readdata_o == {16'h0000, ID_HIGH})
    else $error("high identifier wrong");

  AST_SHARED: assert property (
    hit_m && avm_byteenable_i[0] |=> ctrl_word[8] == $past(wd[5]))
    else $error("mirror write not seen in control word");

  AST_SPEED_AN: assert property (
    reset_n_i && an_enable
    |=> phy_ctrl_o.speed_100 == $past(phy_stat_i.an_speed_100))
    else $error("negotiated speed not driven");

  AST_DUPLEX_AN: assert property (
    reset_n_i && an_enable && !phy_stat_i.an_failed
    |=> phy_ctrl_o.full_duplex == $past(phy_stat_i.an_full_duplex))
    else $error("negotiated duplex not driven");

  AST_FORCE_SPEED_WR: assert property (
    s_wr_ctrl_hi |=> force_100 == $past(wd[13]))
    else $error("forced speed bit not stored");

  AST_FORCE_DUP_WR: assert property (
    s_wr_ctrl_hi |=> force_full == $past(wd[8]))
    else $error("forced duplex bit not stored");

  AST_POWER_DOWN: assert property (
    s_wr_ctrl_hi |-> ##2 phy_ctrl_o.power_down == $past(wd[11], 2))
    else $error("power down not driven");

  AST_TX_CTRL: assert property (
    s_wr_ctrl_lo |-> ##2 phy_ctrl_o.tx_disable == $past(wd[1], 2))
    else $error("transmit disable not driven");

  AST_XOVER_CTRL: assert property (
    s_wr_ctrl_lo |-> ##2
    phy_ctrl_o.crossover_variant_select == $past(wd[5], 2))
    else $error("crossover variant not driven");

  AST_NO_T4: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT) |=> !avm_readdata_o[15])
    else $error("T4 ability reported");

  AST_AN_CAP: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT) |=> avm_readdata_o[3])
    else $error("negotiation ability not reported");

  AST_NO_EXT: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT) |=> !avm_readdata_o[0])
    else $error("extended ability reported");

  AST_LINK_STAT: assert property (
    s_rd_cap(pmcs_pkg::IDX_STAT)
    |=> avm_readdata_o[2] == $past(phy_stat_i.link_up))
    else $error("link bit wrong in status word");

  AST_AN_DONE_MIR: assert property (
    s_rd_cap(pmcs_pkg::IDX_SMIR)
    |=> avm_readdata_o[6] == $past(phy_stat_i.an_complete))
    else $error("negotiation complete wrong in status mirror");

  AST_XOVER_READ: assert property (
    s_rd_cap(pmcs_pkg::IDX_SMIR)
    |=> avm_readdata_o[15] == $past(xover_var))
    else $error("crossover variant wrong in status mirror");

  AST_CTRL_READ: assert property (
    s_rd_cap(pmcs_pkg::IDX_CTRL)
    |=> avm_readdata_o[14] == $past(loopback))
    else $error("loopback wrong in control word");

  AST_CMIR_READ: assert property (
    s_rd_cap(pmcs_pkg::IDX_CMIR)
    |=> avm_readdata_o[8] == $past(loopback))
    else $error("loopback wrong in control mirror");

endmodule // pmcs_phy_regs

/* File: testbench/pmcs_phy_model.sv */
`timescale 1ns/10ps
module pmcs_phy_model #(
  parameter int DONE_CYC = 16
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire pmcs_pkg::pmcs_ctrl_s phy_ctrl_i,
  input  wire logic                 fail_i,
  output pmcs_pkg::pmcs_stat_s      phy_stat_o
);
  logic [7:0] count;
  logic       done;

  // Negotiation restarts on the pulse and settles after a fixed delay
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 8'h00;
      done  <= 1'b0;
    end else if (phy_ctrl_i.an_restart) begin
      count <= 8'h00;
      done  <= 1'b0;
    end else if (!done) begin
      count <= count + 8'h01;
      done  <= (count == 8'(DONE_CYC - 1));
    end
  end

  // Link partner settles on 10 Mb/s full duplex
  assign phy_stat_o = {done & ~fail_i,
                       done & fail_i,
                       1'b0,
                       1'b1,
                       done & ~phy_ctrl_i.power_down};
endmodule // pmcs_phy_model

/* File: testbench/phy_port_mii_ctrl_status_test.sv */
`timescale 1ns/10ps
module phy_port_mii_ctrl_status_test;
  typedef struct {
    logic        wr;
    logic [9:0]  a;
    logic [3:0]  be;
    logic [15:0] d;
    logic [15:0] e;
  } pmcs_row_s;
  localparam logic [9:0] A_CT = 10'h130;
  localparam logic [9:0] A_ST = 10'h138;
  localparam logic [9:0] A_IL = 10'h140;
  localparam logic [9:0] A_IH = 10'h148;
  localparam logic [9:0] A_CM = 10'h180;
  localparam logic [9:0] A_SM = 10'h188;
  localparam logic [9:0] A_UN = 10'h3fc;
  logic                 sys_clk_i;
  logic                 reset_n_i;
  logic [9:0]           avm_address_i;
  logic                 avm_read_i;
  logic                 avm_write_i;
  logic [3:0]           avm_byteenable_i;
  logic [31:0]          avm_writedata_i;
  logic [31:0]          avm_readdata_o;
  logic                 avm_waitrequest_o;
  pmcs_pkg::pmcs_stat_s phy_stat;
  pmcs_pkg::pmcs_ctrl_s phy_ctrl;
  logic                 fail_mode;
  logic [31:0]          q;
  int                   fails;
  int                   n_checks;
  int                   n;
  pmcs_row_s rows [21] = '{
    '{0, A_CT, 4'h3, 16'h0000, 16'h3120},
    '{0, A_ST, 4'h3, 16'h0000, 16'h782c},
    '{1, A_IL, 4'h3, 16'hffff, 16'h3120},
    '{0, A_IL, 4'h3, 16'h0000, 16'h3c3c},
    '{1, A_IH, 4'h3, 16'h0000, 16'h3120},
    '{0, A_IH, 4'h3, 16'h0000, 16'h00c3},
    '{1, A_ST, 4'h3, 16'hffff, 16'h3120},
    '{0, A_ST, 4'h3, 16'h0000, 16'h782c},
    '{1, A_CT, 4'h3, 16'h6100, 16'h6100},
    '{1, A_CT, 4'h3, 16'h0000, 16'h0000},
    '{1, A_CT, 4'h3, 16'hffff, 16'h7b3e},
    '{0, A_CT, 4'h3, 16'h0000, 16'h793e},
    '{0, A_CM, 4'h3, 16'h0000, 16'h5fe0},
    '{1, A_CM, 4'h3, 16'h0000, 16'h0020},
    '{1, A_SM, 4'h3, 16'h0000, 16'h0000},
    '{1, A_CT, 4'h1, 16'hffff, 16'h003e},
    '{1, A_CT, 4'h2, 16'h3000, 16'h303e},
    '{0, A_SM, 4'h3, 16'h0000, 16'h8060},
    '{0, A_UN, 4'h3, 16'h0000, 16'h0000},
    '{1, A_UN, 4'h3, 16'hffff, 16'h303e},
    '{0, A_CT, 4'h3, 16'h0000, 16'h303e}
  };

  // Arbitrary identifier values
  pmcs_phy_regs #(.ID_LOW(16'h3c3c), .ID_HIGH(16'h00c3)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .avm_address_i(avm_address_i), .avm_read_i(avm_read_i),
    .avm_write_i(avm_write_i), .avm_byteenable_i(avm_byteenable_i),
    .avm_writedata_i(avm_writedata_i), .avm_readdata_o(avm_readdata_o),
    .avm_waitrequest_o(avm_waitrequest_o),
    .phy_stat_i(phy_stat), .phy_ctrl_o(phy_ctrl));

  pmcs_phy_model partner (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .phy_ctrl_i(phy_ctrl),
    .fail_i(fail_mode), .phy_stat_o(phy_stat));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t read %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_ctl(input pmcs_pkg::pmcs_ctrl_s g,
                         input pmcs_pkg::pmcs_ctrl_s e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t phy ctrl %h exp %h", $time, g, e);
    end
  endtask

  // Expected PHY controls; partner negotiates 10 Mb/s full duplex
  function automatic pmcs_pkg::pmcs_ctrl_s exp_ctrl(input logic [15:0] c);
    logic dup;
    dup = (c[12] && !fail_mode) ? 1'b1 : c[8];
    return {c[14], c[12] ? 1'b0 : c[13], dup, c[12], c[9], c[11], c[5],
            c[4], c[3], c[1]};
  endfunction

  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [3:0] be, input logic [15:0] d);
    int k;
    k = 0;
    avm_address_i    <= a;
    avm_byteenable_i <= be;
    avm_writedata_i  <= {16'h0000, d};
    avm_write_i      <= wr;
    avm_read_i       <= !wr;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (avm_waitrequest_o !== 1'b0 && k < 40);
    if (avm_waitrequest_o !== 1'b0) begin
      fails++;
      $display("MISMATCH t=%0t bus timeout", $time);
      tally_and_finish();
    end
    q = avm_readdata_o;
    avm_read_i  <= 1'b0;
    avm_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  initial begin
    reset_n_i = 1'b0;
    avm_address_i = 10'h000;
    avm_read_i = 1'b0;
    avm_write_i = 1'b0;
    avm_byteenable_i = 4'h0;
    avm_writedata_i = 32'h0000_0000;
    fail_mode = 1'b0;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].be, rows[i].d);
      @(posedge sys_clk_i);
      if (rows[i].wr) chk_ctl(phy_ctrl, exp_ctrl(rows[i].e));
      else chk_rd(q, {16'h0000, rows[i].e});
    end
    $display("test table done");
    bus(1'b1, A_CT, 4'h3, 16'h3220);
    n = 0;
    repeat (6) begin
      @(posedge sys_clk_i);
      if (phy_ctrl.an_restart === 1'b1) n++;
    end
    chk_rd(32'(n), 32'h0000_0001);
    bus(1'b0, A_CT, 4'h3, 16'h0000);
    chk_rd(q, 32'h0000_3020);
    bus(1'b0, A_ST, 4'h3, 16'h0000);
    chk_rd(q, 32'h0000_7808);
    repeat (30) @(posedge sys_clk_i);
    bus(1'b0, A_ST, 4'h3, 16'h0000);
    chk_rd(q, 32'h0000_782c);
    $display("test restart done");
    fail_mode <= 1'b1;
    bus(1'b1, A_CT, 4'h3, 16'h3220);
    repeat (30) @(posedge sys_clk_i);
    chk_ctl(phy_ctrl, exp_ctrl(16'h3020));
    bus(1'b0, A_ST, 4'h3, 16'h0000);
    chk_rd(q, 32'h0000_780c);
    fail_mode <= 1'b0;
    $display("test fallback done");
    reset_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk_ctl(phy_ctrl, '0);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    bus(1'b0, A_CT, 4'h3, 16'h0000);
    chk_rd(q, 32'h0000_3120);
    chk_ctl(phy_ctrl, exp_ctrl(16'h3120));
    $display("test reset done");
    tally_and_finish();
  end
endmodule // phy_port_mii_ctrl_status_test
